// >>> spira_consts.vh
// Purpose: constants for the spi register access slave
// Assumes: 20 MHz system clock
// Notes:   definitions only
`ifndef SPIRA_CONSTS_VH
`define SPIRA_CONSTS_VH
`define SPIRA_CTL_DIR_BIT   7
`define SPIRA_CTL_AI_BIT    6
`define SPIRA_CTL_PAGE_HI   1
`define SPIRA_CTL_PAGE_LO   0
`define SPIRA_BIT_LAST      3'h7
`define SPIRA_BIT_ZERO      3'h0
`define SPIRA_LEN_ONE       8'h01
`define SPIRA_LEN_ZERO      8'h00
`define SPIRA_DIR_RESET     1'b0
`define SPIRA_SWITCH_NS     50
`define SPIRA_CLK_MHZ       20
`endif

// >>> spira_sync.v
// Purpose: two flip-flop synchroniser for one level
// Assumes: destination clock REF_CLK
// Notes:   first stage read only by second stage
`timescale 1ns/1ps
`default_nettype none
module spira_sync #(
   parameter RST_VAL = 1'b0
) (
   input  wire clk,
   input  wire rst_n,
   input  wire d,
   output reg  q
);
   reg meta_q;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= RST_VAL;
         q      <= RST_VAL;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule
`default_nettype wire

// >>> spira_slave.v
// Purpose: spi slave giving register access to a paged register space
// Assumes: link clock oversampled by REF_CLK; register side same clock
// Notes:   select and clock pass two flops before use
`timescale 1ns/1ps
`default_nettype none
`include "spira_consts.vh"
// Functional notes
// RULE_01: spi access when pin function and pad zero
// RULE_02: host avoids i2c own address under spi
// RULE_03: host holds select high under i2c
// RULE_04: host waits 50ns after interface switch
// RULE_05: four-wire byte based slave up to 26MHz; here SCLK is oversampled by the 20 MHz REF_CLK, so it must stay below 10MHz
// RULE_06: select low starts, select high ends
// RULE_07: control byte: direction, auto-increment, page bits
// RULE_08: direction one reads at polarity zero
// RULE_09: second byte is address within page
// RULE_10: length byte follows, overrides auto-increment
// RULE_11: write each full byte, then advance address
// RULE_12: single byte transfer then wait state
// RULE_13: length mode stops after counted bytes
// RULE_14: no length, auto-increment writes until deselect
// RULE_15: deselect aborts, keeps only complete bytes
// RULE_16: read shifts register, advances after byte
// RULE_17: no length, auto-increment reads until deselect
// RULE_18: data output low while deselected
// RULE_19: default polarity zero, phase zero
// RULE_20: default length field enabled
// RULE_21: all four polarity and phase modes
module spira_slave #(
   parameter AW = 10,
   parameter DW = 8
) (
   input  wire          REF_CLK,
   input  wire          NRST,
   input  wire          SCLK,
   input  wire          SEL_N,
   input  wire          MOSI,
   output reg           MISO,
   input  wire          PIN_FUNCTION_SELECT,
   input  wire          MULTIPURPOSE_PAD_ONE,
   input  wire          CLOCK_POLARITY_CFG,
   input  wire          CLOCK_PHASE_CFG,
   input  wire          DIRECTION_BIT_POLARITY,
   input  wire          LENGTH_FIELD_ENABLE,
   output wire          SPI_ACCESS_SEL,
   output reg  [AW-1:0] REG_ADDR,
   output reg  [DW-1:0] REG_WDATA,
   output reg           REG_WR,
   output reg           REG_RD,
   input  wire [DW-1:0] REG_RDATA,
   output wire          BUSY
);
   // ----------------------------------------------------------------
   // states
   // ----------------------------------------------------------------
   localparam [5:0] ST_IDLE = 6'h01;
   localparam [5:0] ST_CTL  = 6'h02;
   localparam [5:0] ST_ADR  = 6'h04;
   localparam [5:0] ST_LEN  = 6'h08;
   localparam [5:0] ST_DAT  = 6'h10;
   localparam [5:0] ST_WAIT = 6'h20;
   // host-side minimum switch gap, kept for reference
   localparam integer SWITCH_CYC =
      (`SPIRA_SWITCH_NS * `SPIRA_CLK_MHZ + 999) / 1000 < 1 ? 1 :
      (`SPIRA_SWITCH_NS * `SPIRA_CLK_MHZ + 999) / 1000;

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   wire sclk_s;
   wire sel_n_s;
   wire mosi_s;
   wire pad_s;
   spira_sync #(.RST_VAL(1'b0)) u_sync_clk (
      .clk   (REF_CLK),
      .rst_n (NRST),
      .d     (SCLK),
      .q     (sclk_s)
   );
   spira_sync #(.RST_VAL(1'b1)) u_sync_sel (
      .clk   (REF_CLK),
      .rst_n (NRST),
      .d     (SEL_N),
      .q     (sel_n_s)
   );
   spira_sync #(.RST_VAL(1'b0)) u_sync_mosi (
      .clk   (REF_CLK),
      .rst_n (NRST),
      .d     (MOSI),
      .q     (mosi_s)
   );
   spira_sync #(.RST_VAL(1'b1)) u_sync_pad (
      .clk   (REF_CLK),
      .rst_n (NRST),
      .d     (MULTIPURPOSE_PAD_ONE),
      .q     (pad_s)
   );

   // ----------------------------------------------------------------
   // access arbitration
   // ----------------------------------------------------------------
   // RULE_01: spi route select
   assign SPI_ACCESS_SEL = ~PIN_FUNCTION_SELECT & ~pad_s;

   // ----------------------------------------------------------------
   // clock edge detection
   // ----------------------------------------------------------------
   reg  sclk_q;
   reg  sel_n_q;
   always @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         sclk_q  <= 1'b0;
         sel_n_q <= 1'b1;
      end else begin
         sclk_q  <= sclk_s;
         sel_n_q <= sel_n_s;
      end
   end
   wire rise     = sclk_s & ~sclk_q;
   wire fall     = ~sclk_s & sclk_q;
   // RULE_19: mode zero samples on rising edge
   // RULE_21: mode selects sample edge
   wire lead     = CLOCK_POLARITY_CFG ? fall : rise;
   wire trail    = CLOCK_POLARITY_CFG ? rise : fall;
   wire samp     = CLOCK_PHASE_CFG ? trail : lead;
   wire shift    = CLOCK_PHASE_CFG ? lead : trail;
   wire active   = ~sel_n_s & SPI_ACCESS_SEL;
   // RULE_06: frame start on select fall
   wire start    = sel_n_q & ~sel_n_s & SPI_ACCESS_SEL;

   // ----------------------------------------------------------------
   // frame state
   // ----------------------------------------------------------------
   reg  [5:0]    st_q;
   reg  [2:0]    bit_q;
   reg  [7:0]    sh_q;
   reg           rd_q;
   reg           ai_q;
   reg  [1:0]    page_q;
   reg  [7:0]    left_q;
   reg           lenmode_q;
   reg  [7:0]    tx_q;
   reg           tx_first_q;
   wire [7:0]    byte_in = {sh_q[6:0], mosi_s};
   // RULE_05: byte based transfer unit
   wire          byte_done = samp & (bit_q == `SPIRA_BIT_LAST);
   // RULE_12: single byte ends after one
   // RULE_13: counted bytes end
   wire          last_byte = lenmode_q ? (left_q == `SPIRA_LEN_ONE) : ~ai_q;

   assign BUSY = ~st_q[0];

   always @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         st_q       <= ST_IDLE;
         bit_q      <= `SPIRA_BIT_ZERO;
         sh_q       <= 8'h00;
         rd_q       <= `SPIRA_DIR_RESET;
         ai_q       <= 1'b0;
         page_q     <= 2'h0;
         left_q     <= `SPIRA_LEN_ZERO;
         lenmode_q  <= 1'b1;
         tx_q       <= 8'h00;
         tx_first_q <= 1'b0;
         REG_ADDR   <= {AW{1'b0}};
         REG_WDATA  <= {DW{1'b0}};
         REG_WR     <= 1'b0;
         REG_RD     <= 1'b0;
         MISO       <= 1'b0;
      end else begin
         REG_WR <= 1'b0;
         REG_RD <= 1'b0;
         if (!active) begin
            // RULE_06: deselect ends frame
            // RULE_15: partial byte dropped
            st_q  <= ST_IDLE;
            bit_q <= `SPIRA_BIT_ZERO;
            // RULE_18: output low when deselected
            MISO  <= 1'b0;
         end else begin
            if (start) begin
               st_q       <= ST_CTL;
               bit_q      <= `SPIRA_BIT_ZERO;
               // RULE_20: latch length mode per frame
               lenmode_q  <= LENGTH_FIELD_ENABLE;
               tx_first_q <= 1'b0;
            end else if (samp) begin
               sh_q  <= byte_in;
               bit_q <= bit_q + 3'h1;
            end
            if (byte_done) begin
               case (st_q)
                  ST_CTL: begin
                     // RULE_07: control byte fields
                     // RULE_08: direction polarity
                     rd_q   <= byte_in[`SPIRA_CTL_DIR_BIT] ^ DIRECTION_BIT_POLARITY;
                     ai_q   <= byte_in[`SPIRA_CTL_AI_BIT];
                     page_q <= byte_in[`SPIRA_CTL_PAGE_HI:`SPIRA_CTL_PAGE_LO];
                     st_q   <= ST_ADR;
                  end
                  ST_ADR: begin
                     // RULE_09: address within page
                     REG_ADDR <= {page_q, byte_in};
                     // RULE_10: length byte follows
                     st_q     <= lenmode_q ? ST_LEN : ST_DAT;
                     REG_RD   <= rd_q & ~lenmode_q;
                  end
                  ST_LEN: begin
                     left_q <= byte_in;
                     st_q   <= (byte_in == `SPIRA_LEN_ZERO) ? ST_WAIT : ST_DAT;
                     REG_RD <= rd_q & (byte_in != `SPIRA_LEN_ZERO);
                  end
                  ST_DAT: begin
                     if (!rd_q) begin
                        // RULE_11: commit full byte
                        // RULE_14: continue until deselect
                        REG_WDATA <= byte_in;
                        REG_WR    <= 1'b1;
                     end
                     left_q <= left_q - 8'h01;
                     st_q   <= last_byte ? ST_WAIT : ST_DAT;
                  end
                  ST_WAIT: begin
                     st_q <= ST_WAIT;
                  end
                  default: begin
                     st_q <= ST_IDLE;
                  end
               endcase
            end
            // read data is combinational off REG_ADDR, so the address must
            // step before the next fetch, not together with it
            // RULE_16: advance after full byte
            if (byte_done && st_q == ST_DAT && !last_byte) begin
               REG_RD <= rd_q;
            end
            if (REG_WR || (byte_done && st_q == ST_DAT && rd_q && tx_first_q)) begin
               REG_ADDR <= REG_ADDR + {{(AW-1){1'b0}}, 1'b1};
            end
            if (REG_RD) begin
               tx_q       <= REG_RDATA;
               tx_first_q <= 1'b1;
               if (CLOCK_PHASE_CFG == 1'b0) begin
                  MISO <= REG_RDATA[7];
               end
            end else if (shift && st_q == ST_DAT && rd_q) begin
               // RULE_17: stream successive bytes
               if (bit_q == `SPIRA_BIT_ZERO && !CLOCK_PHASE_CFG) begin
                  MISO <= tx_q[7];
               end else begin
                  MISO <= tx_q[7 - bit_q];
               end
            end else if (st_q != ST_DAT) begin
               MISO <= 1'b0;
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> spira_slave_monitor.sv
// Purpose: port checks for spira_slave
// Assumes: one clock domain, REF_CLK
// Notes:   bound from the bench
`timescale 1ns/1ps
`default_nettype none
module spira_slave_monitor #(
   parameter AW = 10
) (
   input wire logic          REF_CLK,
   input wire logic          NRST,
   input wire logic          SEL_N,
   input wire logic          MISO,
   input wire logic          PIN_FUNCTION_SELECT,
   input wire logic          MULTIPURPOSE_PAD_ONE,
   input wire logic          SPI_ACCESS_SEL,
   input wire logic [AW-1:0] REG_ADDR,
   input wire logic          REG_WR,
   input wire logic          REG_RD,
   input wire logic          BUSY
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!NRST);
   a_route_spi: assert property (
      (!PIN_FUNCTION_SELECT && !MULTIPURPOSE_PAD_ONE)[*4] |-> SPI_ACCESS_SEL) else $error("no route");
   a_route_pad: assert property (
      MULTIPURPOSE_PAD_ONE[*4] |-> !SPI_ACCESS_SEL) else $error("pad route");
   a_route_pin: assert property (
      PIN_FUNCTION_SELECT |-> !SPI_ACCESS_SEL) else $error("pin route");
   a_miso_idle: assert property (
      SEL_N[*5] |-> !MISO) else $error("miso not low");
   a_frame_start: assert property (
      $fell(SEL_N) && SPI_ACCESS_SEL |-> ##[1:6] BUSY) else $error("no frame");
   a_idle_quiet: assert property (
      SEL_N[*8] |-> !BUSY && !REG_WR) else $error("busy after end");
   a_wr_single: assert property (
      REG_WR |=> !REG_WR) else $error("long write");
   a_addr_step: assert property (
      REG_WR |=> REG_ADDR == $past(REG_ADDR) + 1'b1) else $error("no step");
   c_write: cover property (REG_WR);
   c_read: cover property (REG_RD);
   c_abort: cover property ($rose(SEL_N) && BUSY);
endmodule
`default_nettype wire

// >>> spira_host.sv
// Purpose: spi master model for the slave link
// Assumes: 400 ns bit period, msb first
// Notes:   clock idles at polarity level between frames
`timescale 1ns/1ps
`default_nettype none
module spira_host (
   output var logic sclk,
   output var logic sel_n,
   output var logic mosi,
   input wire logic miso,
   input wire logic cpol,
   input wire logic cpha
);
   initial {sclk, sel_n, mosi} = 3'b010;
   task open_frame;
      sclk = cpol;
      #200 sel_n = 1'b0;
      #200;
   endtask
   task xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
      int i;
      rx = 8'h00;
      for (i = 7; i > 7 - nb; i--) begin
         if (!cpha) mosi = tx[i];
         #100 sclk = ~cpol;
         if (cpha) mosi = tx[i];
         #100 if (!cpha) rx[i] = miso;
         #100 sclk = cpol;
         #100 if (cpha) rx[i] = miso;
      end
   endtask
   task close_frame;
      #200 sel_n = 1'b1;
      mosi = ~mosi;
      #400;
   endtask
endmodule
`default_nettype wire

// >>> spira_slave_test.sv
// Purpose: self-checking bench for spira_slave
// Assumes: host model drives the link
// Notes:   register space modelled here, exp_m holds expectations
`timescale 1ns/1ps
`default_nettype none
module spira_slave_test;
   logic       clk, nrst, pin, pad, cpol, cpha, rwpol, len_en, sclk, sel_n, mosi, miso, wr, acc;
   logic [9:0] addr;
   logic [7:0] wdata;
   logic [7:0] mem [0:1023];
   logic [7:0] exp_m [0:1023];
   int         fail_count, n_tests, t;
   spira_slave DUT (.REF_CLK(clk), .NRST(nrst), .SCLK(sclk), .SEL_N(sel_n), .MOSI(mosi),
      .MISO(miso), .PIN_FUNCTION_SELECT(pin), .MULTIPURPOSE_PAD_ONE(pad),
      .CLOCK_POLARITY_CFG(cpol), .CLOCK_PHASE_CFG(cpha), .DIRECTION_BIT_POLARITY(rwpol),
      .LENGTH_FIELD_ENABLE(len_en), .SPI_ACCESS_SEL(acc), .REG_ADDR(addr), .REG_WDATA(wdata),
      .REG_WR(wr), .REG_RD(), .REG_RDATA(mem[addr]), .BUSY());
   spira_host u_host (.sclk(sclk), .sel_n(sel_n), .mosi(mosi), .miso(miso), .cpol(cpol),
      .cpha(cpha));
   always @(posedge clk) if (wr === 1'b1) mem[addr] <= wdata;
   task chk8(input logic [7:0] got, want);
      n_tests++;
      if (got !== want) begin
         fail_count++;
         $display("mismatch at %0t: got %h want %h", $time, got, want);
      end
   endtask
   task give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task frame(input logic rd_op, ai, input logic [1:0] pg, input logic [7:0] ad, ln,
              input int n, part);
      int         k, eff;
      logic [7:0] tx, rx;
      logic [9:0] b;
      eff = len_en ? int'(ln) : (ai ? n : 1);
      if (eff > n) eff = n;
      if (pin) eff = 0;
      u_host.open_frame();
      u_host.xfer({rd_op ^ rwpol, ai, 4'h0, pg}, 8, rx);
      u_host.xfer(ad, 8, rx);
      if (len_en) u_host.xfer(ln, 8, rx);
      for (k = 0; k < n; k++) begin
         b = {pg, ad} + 10'(k);
         tx = 8'($urandom);
         u_host.xfer(tx, 8, rx);
         if (k < eff && rd_op) chk8(rx, exp_m[b]);
         if (k < eff && !rd_op) exp_m[b] = tx;
      end
      if (part > 0) u_host.xfer(8'($urandom), part, rx);
      u_host.close_frame();
      for (k = 0; k <= n; k++) chk8(mem[{pg, ad} + 10'(k)], exp_m[{pg, ad} + 10'(k)]);
      $display("test done at %0t", $time);
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      #2_000_000;
      fail_count++;
      give_verdict();
   end
   initial begin
      {nrst, pin, pad, cpol, cpha, rwpol, len_en} = 7'h01;
      fail_count = 0;
      n_tests = 0;
      void'($urandom(96));
      for (t = 0; t < 1024; t++) begin
         mem[t] = 8'($urandom);
         exp_m[t] = mem[t];
      end
      repeat (4) @(posedge clk);
      #13 nrst = 1'b1;
      repeat (4) @(posedge clk);
      #13;
      frame(0, 1, 2'h3, 8'hf0, 8'h01, 3, 0);
      frame(0, 1, 2'h2, 8'h40, 8'h03, 3, 5);
      frame(1, 0, 2'h3, 8'hf0, 8'h02, 3, 0);
      len_en = 1'b0;
      frame(0, 0, 2'h1, 8'h20, 8'h00, 2, 0);
      frame(0, 1, 2'h1, 8'h30, 8'h00, 4, 4);
      frame(1, 1, 2'h1, 8'h30, 8'h00, 3, 0);
      pin = 1'b1;
      frame(0, 1, 2'h0, 8'h08, 8'h00, 2, 0);
      pin = 1'b0;
      pad = 1'b1;
      #200 chk8({7'h0, acc}, 8'h00);
      pad = 1'b0;
      #100;
      for (t = 0; t < 24; t++) begin
         {cpha, cpol} = 2'(t);
         rwpol = 1'($urandom);
         len_en = 1'($urandom);
         frame(1'($urandom), 1'($urandom), 2'($urandom), 8'($urandom_range(239)),
               8'($urandom_range(4)), $urandom_range(4, 1), 3 * $urandom_range(1));
      end
      give_verdict();
   end
endmodule
bind spira_slave spira_slave_monitor #(.AW(AW)) u_mon (.REF_CLK(REF_CLK), .NRST(NRST),
   .SEL_N(SEL_N), .MISO(MISO), .PIN_FUNCTION_SELECT(PIN_FUNCTION_SELECT),
   .MULTIPURPOSE_PAD_ONE(MULTIPURPOSE_PAD_ONE), .SPI_ACCESS_SEL(SPI_ACCESS_SEL),
   .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .BUSY(BUSY));
`default_nettype wire
